// >>> dv/lvp_assertions.sv
// checker for the low-voltage priority bank
`timescale 1ns/1ps
`default_nettype none
module lvp_chk
   import lvp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   // request path
   input wire logic lv_irq_raw,
   input wire lvp_prio_t lv_level_q,
   input wire logic lv_req_q
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_rst_level: assert property ($rose(rst_n) |-> lv_level_q == 3'h4)
      else $error("level not 4 after reset");
   a_wr_level: assert property (reg_wr && reg_addr == 4'h1 |-> ##2
      lv_level_q == $past(reg_wdata[2:0], 2)) else $error("level not written");
   a_off_quiet: assert property (lv_level_q == 3'h0 |-> !lv_req_q)
      else $error("request while disabled");
   a_req_follow: assert property ($past(rst_n) && lv_level_q != 3'h0 |->
      lv_req_q == $past(lv_irq_raw)) else $error("request lost");
   a_hi_zero: assert property (reg_rd && reg_addr == 4'h1 |=>
      reg_rdata[15:3] == 13'h0000) else $error("upper bits not zero");
   a_rd_back: assert property (reg_rd && reg_addr == 4'h1 |=>
      reg_rdata[2:0] == lv_level_q) else $error("readback differs");
   a_rd_idle: assert property (!(reg_rd && reg_addr <= 4'h1) |=>
      reg_rdata == 16'h0000) else $error("read data not zero when idle");
   // main scenarios
   cover property (lv_req_q);
   cover property ($rose(rst_n));
   cover property (reg_wr && reg_addr == 4'h1 && reg_wdata[2:0] == 3'h7);
   cover property (lv_level_q == 3'h0);
endmodule
bind lvp_prio_regs lvp_chk u_chk (.*);
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench of the low-voltage priority bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import lvp_pkg::*;
   logic sys_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, lv_irq_raw = 0, lv_req_q;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   lvp_prio_t lv_level_q;
   int n_mismatch = 0, tests_run = 0;
   lvp_prio_regs DUT (.*);
   initial forever #12.5 sys_clk = ~sys_clk;
   // compare one value
   task chk(string s, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   // one-cycle write strobe
   task wr(logic [3:0] a, logic [15:0] d);
      @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
      @(posedge sys_clk) reg_wr <= 1'b0;
   endtask
   // one-cycle read strobe, data checked next cycle
   task rd(logic [3:0] a, logic [15:0] e);
      @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge sys_clk) reg_rd <= 1'b0;
      #1 chk("rdata", e, reg_rdata);
   endtask
   task give_verdict;
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // reset, every code, unmapped access
   initial begin
      repeat (8) @(posedge sys_clk);
      {rst_n, lv_irq_raw} <= 2'b11;
      rd(4'h1, 16'h0004);
      rd(4'h0, 16'h0440);
      $display("reset test done");
      for (int c = 0; c < 8; c++) begin
         wr(4'h1, 16'hfff8 | 16'(c));
         rd(4'h1, 16'(c));
         chk("level", 16'(c), {13'h0000, lv_level_q});
         chk("req", 16'(c != 0), {15'h0000, lv_req_q});
      end
      $display("code test done");
      // request follows the raw event while the field is non-zero
      @(posedge sys_clk) lv_irq_raw <= 1'b0;
      @(posedge sys_clk) #1 chk("req", 16'h0000, {15'h0000, lv_req_q});
      @(posedge sys_clk) lv_irq_raw <= 1'b1;
      @(posedge sys_clk) #1 chk("req", 16'h0001, {15'h0000, lv_req_q});
      $display("request test done");
      // serial-error register keeps its own fields only
      wr(4'h0, 16'hf35f);
      rd(4'h0, 16'h0350);
      rd(4'h1, 16'h0007);
      $display("serial register test done");
      wr(4'h5, 16'hffff);
      rd(4'h5, 16'h0000);
      rd(4'h1, 16'h0007);
      rd(4'h0, 16'h0350);
      $display("unmapped test done");
      // mid-run reset brings back the reset values
      @(posedge sys_clk) rst_n <= 1'b0;
      #1 chk("rst rdata", 16'h0000, reg_rdata);
      chk("rst level", 16'h0004, {13'h0000, lv_level_q});
      chk("rst req", 16'h0000, {15'h0000, lv_req_q});
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(4'h1, 16'h0004);
      rd(4'h0, 16'h0440);
      $display("mid-run reset test done");
      give_verdict();
   end
endmodule
`default_nettype wire

// >>> rtl/lvp_prio_field.sv
// one three-bit priority field with decode of its enable
`timescale 1ns/1ps
`default_nettype none
`include "lvp_map.svh"
module lvp_prio_field
   import lvp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // write side
   input wire logic wr_en,
   input wire lvp_prio_t wr_val,
   // state
   output lvp_prio_t prio_q,
   output logic enabled
);
   // field storage, loads level 4 on reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prio_q <= `LVP_PRIO_RST;
      end else if (wr_en) begin
         prio_q <= wr_val;
      end
   end

   // code equals level, zero means off
   assign enabled = (prio_q != `LVP_PRIO_OFF);
endmodule
`default_nettype wire

// >>> rtl/lvp_prio_regs.sv
// priority bank: serial-error and low-voltage priority registers
`timescale 1ns/1ps
`default_nettype none
`include "lvp_map.svh"
module lvp_prio_regs
   import lvp_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // register port
   input wire logic [`LVP_ADDR_W-1:0] reg_addr,
   input wire logic [`LVP_DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [`LVP_DATA_W-1:0] reg_rdata,
   // interrupt request input and outward view
   input wire logic lv_irq_raw,
   output lvp_prio_t lv_level_q,
   output logic lv_req_q
);
   // register layout
   //   index 0: port 2 error field in bits 10..8, port 1 error field in bits 6..4
   //   index 0: bits 15..11, 7 and 3..0 read zero
   //   index 1: low-voltage field in bits 2..0, bits 15..3 read zero
   //   other indices: writes dropped, reads return zero
   //   fields: code equals level, 000 disables the source
   //   reset: every field 100, level 4, request low, read data zero

   // register selects and strobes
   logic sel_lv;
   logic sel_se;
   logic wr_lv;
   logic wr_se;
   logic rd_lv;
   logic rd_se;

   // write data restricted to the implemented bits
   logic [`LVP_DATA_W-1:0] wdata_lv_m;
   logic [`LVP_DATA_W-1:0] wdata_se_m;
   lvp_prio_t wval_lv;
   lvp_prio_t wval_sp1;
   lvp_prio_t wval_sp2;

   // field state
   lvp_prio_t lv_prio;
   lvp_prio_t sp1_prio;
   lvp_prio_t sp2_prio;
   logic lv_en;

   // read side
   logic [`LVP_DATA_W-1:0] img_lv;
   logic [`LVP_DATA_W-1:0] img_se;
   logic [`LVP_DATA_W-1:0] rdata_d;

   // level and request next values
   lvp_prio_t lv_level_d;
   logic lv_req_d;

   // index decode, one select at most
   // the default arm covers every unmapped index
   always_comb begin
      sel_lv = 1'b0;
      sel_se = 1'b0;
      unique case (reg_addr)
         `LVP_OFS_LOW_VOLT: begin
            sel_lv = 1'b1;
         end
         `LVP_OFS_SERIAL_ERR: begin
            sel_se = 1'b1;
         end
         default: begin
            sel_lv = 1'b0;
            sel_se = 1'b0;
         end
      endcase
   end

   // strobes qualified by the select, unmapped indices hit nothing
   // a read has no side effect on any field
   assign wr_lv = reg_wr && sel_lv;
   assign wr_se = reg_wr && sel_se;
   assign rd_lv = reg_rd && sel_lv;
   assign rd_se = reg_rd && sel_se;

   // only the implemented bits reach the fields
   // masking first keeps stray upper write bits out of every slice
   assign wdata_lv_m = reg_wdata & `LVP_LV_WMASK;
   assign wdata_se_m = reg_wdata & `LVP_SE_WMASK;

   // field slices of the masked write data
   // each field sees exactly its own three bits
   assign wval_lv = wdata_lv_m[`LVP_LV_LSB +: `LVP_PRIO_W];
   assign wval_sp1 = wdata_se_m[`LVP_SP1_LSB +: `LVP_PRIO_W];
   assign wval_sp2 = wdata_se_m[`LVP_SP2_LSB +: `LVP_PRIO_W];

   // low-voltage field and its zero-code decode, loads level 4 on reset
   lvp_prio_field u_lv (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_en(wr_lv),
      .wr_val(wval_lv),
      .prio_q(lv_prio),
      .enabled(lv_en)
   );

   // serial port 1 error field, enable not used here
   // both serial fields share one strobe, each keeps its own slice
   lvp_prio_field u_sp1 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_en(wr_se),
      .wr_val(wval_sp1),
      .prio_q(sp1_prio),
      .enabled()
   );

   // serial port 2 error field, enable not used here
   // same reset level as the other fields
   lvp_prio_field u_sp2 (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .wr_en(wr_se),
      .wr_val(wval_sp2),
      .prio_q(sp2_prio),
      .enabled()
   );

   // low-voltage register image, upper bits tied to zero
   always_comb begin
      img_lv = `LVP_ZERO16;
      img_lv[`LVP_LV_LSB +: `LVP_PRIO_W] = lv_prio;
   end

   // serial-error register image, gaps between fields read zero
   always_comb begin
      img_se = `LVP_ZERO16;
      img_se[`LVP_SP1_LSB +: `LVP_PRIO_W] = sp1_prio;
      img_se[`LVP_SP2_LSB +: `LVP_PRIO_W] = sp2_prio;
   end

   // read mux, zero when no read or at an unmapped index
   // an idle bus reads zero, so a stale image never reaches the master
   always_comb begin
      rdata_d = `LVP_ZERO16;
      if (rd_lv) begin
         rdata_d = img_lv;
      end else if (rd_se) begin
         rdata_d = img_se;
      end else begin
         rdata_d = `LVP_ZERO16;
      end
   end

   // read data one cycle after the strobe, zero in every other cycle
   // one cycle of data per strobe, matching the one-cycle strobes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `LVP_ZERO16;
      end else begin
         reg_rdata <= rdata_d;
      end
   end

   // code to level: 001 lowest, 111 highest, 000 leaves the source off
   // a table rather than a wire-through, so a remapped level stays local
   always_comb begin
      lv_level_d = `LVP_LEVEL_OFF;
      unique case (lv_prio)
         `LVP_PRIO_OFF: begin
            lv_level_d = `LVP_LEVEL_OFF;
         end
         `LVP_CODE_L1: begin
            lv_level_d = `LVP_LEVEL_1;
         end
         `LVP_CODE_L2: begin
            lv_level_d = `LVP_LEVEL_2;
         end
         `LVP_CODE_L3: begin
            lv_level_d = `LVP_LEVEL_3;
         end
         `LVP_CODE_L4: begin
            lv_level_d = `LVP_LEVEL_4;
         end
         `LVP_CODE_L5: begin
            lv_level_d = `LVP_LEVEL_5;
         end
         `LVP_CODE_L6: begin
            lv_level_d = `LVP_LEVEL_6;
         end
         `LVP_CODE_L7: begin
            lv_level_d = `LVP_LEVEL_7;
         end
      endcase
   end

   // outward level, one cycle behind the field
   // the lag buys a flop-driven output; the read path shows the code at once
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lv_level_q <= `LVP_PRIO_RST;
      end else begin
         lv_level_q <= lv_level_d;
      end
   end

   // request next value, forced idle while the field is zero
   // the raw level is taken as is, any edge shaping lives upstream
   always_comb begin
      lv_req_d = `LVP_REQ_IDLE;
      if (lv_en) begin
         lv_req_d = lv_irq_raw;
      end
   end

   // registered request; the raw event comes from logic on this clock
   // and so passes no synchroniser
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lv_req_q <= `LVP_REQ_IDLE;
      end else begin
         lv_req_q <= lv_req_d;
      end
   end
endmodule
`default_nettype wire

// >>> shared/lvp_map.svh
// register map, field layout and reset values of the low-voltage priority bank
// Contract
// - three-bit read/write low-voltage-detect priority field in bits 2 to 0
// - field value 111 means priority level 7, the highest
// - codes 001 to 111 map one-to-one onto levels 1 to 7 ascending
// - field value 000 disables the source, no request ever produced
// - bits 15 to 3 unimplemented, read as zero, writes ignored
`ifndef LVP_MAP_SVH
`define LVP_MAP_SVH
`define LVP_ADDR_W 4
`define LVP_DATA_W 16
`define LVP_OFS_SERIAL_ERR 4'h0
`define LVP_OFS_LOW_VOLT 4'h1
`define LVP_PRIO_W 3
`define LVP_PRIO_RST 3'h4
`define LVP_PRIO_OFF 3'h0
`define LVP_SP1_LSB 4
`define LVP_SP2_LSB 8
`define LVP_LV_LSB 0
`define LVP_ZERO16 16'h0000
`define LVP_LV_WMASK 16'h0007
`define LVP_SE_WMASK 16'h0770
`define LVP_REQ_IDLE 1'b0
`define LVP_LEVEL_OFF 3'h0
`define LVP_CODE_L1 3'h1
`define LVP_CODE_L2 3'h2
`define LVP_CODE_L3 3'h3
`define LVP_CODE_L4 3'h4
`define LVP_CODE_L5 3'h5
`define LVP_CODE_L6 3'h6
`define LVP_CODE_L7 3'h7
`define LVP_LEVEL_1 3'h1
`define LVP_LEVEL_2 3'h2
`define LVP_LEVEL_3 3'h3
`define LVP_LEVEL_4 3'h4
`define LVP_LEVEL_5 3'h5
`define LVP_LEVEL_6 3'h6
`define LVP_LEVEL_7 3'h7
`endif

// >>> shared/lvp_pkg.sv
// types of the low-voltage priority bank
`default_nettype none
package lvp_pkg;
   typedef logic [2:0] lvp_prio_t;
endpackage
`default_nettype wire
